// file: rtl/dac_update_latch_control.sv
/*
  Digital front end of one 12-bit voltage-mode converter channel: data byte
  and control registers on the special-function-register bus, alignment and
  transfer into the converter input latch, enable of the analog core.
  Assumes one-cycle write and read strobes and one-cycle timer overflow pulses,
  all synchronous to clk_i.
*/
`timescale 1ns/100ps

`include "dac_update_cfg.svh"

// Overview of operation
// (R01) Mode 00: high-byte write updates the latch
// (R02) Mode 01: timer 3 overflow updates the latch
// (R03) Enable bit 7 powers core up or down
// (R04) Eight-bit form: high[7:0], low[7:4]
// (R05) Five/six/seven-bit forms split high and low
// (R06) Modes 10/11: timer 4 / timer 2 overflow
// (R07) Timer modes hold both bytes until overflow
// (R08) Low reads written value, high reads latch
// (R09) Disabled channel holds output high-impedance
// (R10) Format 000 nibble, 001-011 five-seven, 1xx eight
module dac_update_latch_control
  import dac_update_pkg::*;
(
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  // Register bus
  input  wire byte_t sfr_addr_i,
  input  wire logic  sfr_wr_i,
  input  wire byte_t sfr_wdata_i,
  input  wire logic  sfr_rd_i,
  output byte_t      sfr_rdata_o,
  // Timer overflow events
  input  wire logic  timer2_ovf_i,
  input  wire logic  timer3_ovf_i,
  input  wire logic  timer4_ovf_i,
  // Converter core
  output conv_word_t conv_data_o,
  output logic       conv_enable_o,
  output logic       conv_out_en_o,
  output logic       conv_update_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  byte_t      low_wr_r;     // Last value written to the low byte
  byte_t      high_wr_r;    // Held high byte
  byte_t      high_latch_r; // High byte at the latch
  byte_t      ctl_r;
  byte_t      rdata_r;
  conv_word_t conv_word_r;
  logic       enable_r;
  logic       out_en_r;
  logic       update_r;

  byte_t      low_wr_nxt;
  byte_t      high_wr_nxt;
  byte_t      high_latch_nxt;
  byte_t      ctl_nxt;
  byte_t      rdata_nxt;
  conv_word_t conv_word_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and control fields
  // Unmapped addresses match nothing: writes drop, reads give zero
  wire wr_low   = sfr_wr_i && (sfr_addr_i == `ADDR_DATA_LOW);
  wire wr_high  = sfr_wr_i && (sfr_addr_i == `ADDR_DATA_HIGH);
  wire wr_ctl   = sfr_wr_i && (sfr_addr_i == `ADDR_CONTROL);
  wire rd_low   = sfr_rd_i && (sfr_addr_i == `ADDR_DATA_LOW);
  wire rd_high  = sfr_rd_i && (sfr_addr_i == `ADDR_DATA_HIGH);
  wire rd_ctl   = sfr_rd_i && (sfr_addr_i == `ADDR_CONTROL);

  update_mode_t    mode;
  word_alignment_t fmt;
  assign mode = ctl_r[`CTL_MODE_HI:`CTL_MODE_LO];
  assign fmt  = ctl_r[`CTL_FMT_HI:`CTL_FMT_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Transfer triggers
  wire on_write  = (mode == `MODE_ON_WRITE) && wr_high;                     // R01
  wire t3_event  = (mode == `MODE_TIMER3) && timer3_ovf_i;                  // R02
  wire t4_event  = (mode == `MODE_TIMER4) && timer4_ovf_i;                  // R06
  wire t2_event  = (mode == `MODE_TIMER2) && timer2_ovf_i;                  // R06
  wire on_timer  = t3_event || t4_event || t2_event;                        // R07
  wire transfer  = on_write || on_timer;

  // Bytes presented to the latch: the fresh high write, or the held pair
  // An overflow in the same cycle as a high write moves the pair held
  // before that write; the new byte waits for the next overflow. The mode
  // standing at the overflow edge decides which timer counts.
  byte_t xfer_high;
  assign xfer_high = on_write ? sfr_wdata_i : high_wr_r;                    // R01 R07

  // Word assembly
  conv_word_t aligned_word;
  word_align u_align (
    .high_i           (xfer_high),
    .low_i            (low_wr_r),
    .word_alignment_i (fmt),
    .word_o           (aligned_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state values
  assign low_wr_nxt     = wr_low ? sfr_wdata_i : low_wr_r;                  // R07
  assign high_wr_nxt    = wr_high ? sfr_wdata_i : high_wr_r;                // R07
  assign high_latch_nxt = transfer ? xfer_high : high_latch_r;
  assign conv_word_nxt  = transfer ? aligned_word : conv_word_r;            // R01 R02
  assign ctl_nxt        = wr_ctl ? {sfr_wdata_i[7], 2'h0, sfr_wdata_i[4:0]} : ctl_r;

  // Read mux: low shows written value, high shows the latch
  assign rdata_nxt = rd_low  ? low_wr_r     :                               // R08
                     rd_high ? high_latch_r :                               // R08
                     rd_ctl  ? ctl_r        :
                               `RST_READ_DATA;

  ////////////////////////////////////////////////////////////////////////////
  // Data registers
  // Low byte keeps the last written value; reads never see the latch
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      low_wr_r <= `RST_DATA_LOW;
    end else begin
      low_wr_r <= low_wr_nxt;                                               // R08
    end
  end

  // High byte held until the selected transfer takes it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      high_wr_r <= `RST_DATA_HIGH;
    end else begin
      high_wr_r <= high_wr_nxt;                                             // R07
    end
  end

  // High byte as it stands at the latch, for bus reads
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      high_latch_r <= `RST_DATA_HIGH;
    end else begin
      high_latch_r <= high_latch_nxt;                                       // R08
    end
  end

  // Converter input latch; moves only on a transfer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      conv_word_r <= `RST_WORD;
    end else begin
      conv_word_r <= conv_word_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and read data
  // Unused bits 6:5 are dropped on write so they read back as zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctl_r <= `RST_CONTROL;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= `RST_READ_DATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core enable and output drive
  // Enable bit as it will stand after this edge
  logic enable_nxt;
  assign enable_nxt = ctl_nxt[`CTL_ENABLE_BIT];

  // Core and output drive both follow the bit at the write edge, so the
  // pin is never driven while the core is still in shutdown
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      enable_r <= 1'h0;
    end else begin
      enable_r <= enable_nxt;                                               // R03
    end
  end

  // Output enable low holds the pin high-impedance while disabled
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_en_r <= 1'h0;
    end else begin
      out_en_r <= enable_nxt;                                               // R09
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer strobe
  // One-cycle pulse in the cycle the latch shows a new word
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      update_r <= 1'h0;
    end else begin
      update_r <= transfer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign sfr_rdata_o   = rdata_r;
  assign conv_data_o   = conv_word_r;
  assign conv_enable_o = enable_r;
  assign conv_out_en_o = out_en_r;
  assign conv_update_o = update_r;

endmodule // dac_update_latch_control

// file: rtl/dac_update_cfg.svh
/*
  Register offsets, field positions, reset values and encodings of the
  converter update and latch control block.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef DAC_UPDATE_CFG_SVH
`define DAC_UPDATE_CFG_SVH

// Register addresses on the special-function-register bus
`define ADDR_DATA_LOW    8'hD2
`define ADDR_DATA_HIGH   8'hD3
`define ADDR_CONTROL     8'hD4

// Reset values
`define RST_DATA_LOW     8'h00
`define RST_DATA_HIGH    8'h00
`define RST_CONTROL      8'h00
`define RST_READ_DATA    8'h00
`define RST_WORD         12'h000

// Control register field positions
`define CTL_ENABLE_BIT   7
`define CTL_MODE_HI      4
`define CTL_MODE_LO      3
`define CTL_FMT_HI       2
`define CTL_FMT_LO       0

// Update mode encodings
`define MODE_ON_WRITE    2'h0
`define MODE_TIMER3      2'h1
`define MODE_TIMER4      2'h2
`define MODE_TIMER2      2'h3

// Alignment encodings (1xx selects the eight-bit form)
`define FMT_NIBBLE       3'h0
`define FMT_FIVE         3'h1
`define FMT_SIX          3'h2
`define FMT_SEVEN        3'h3

`endif

// file: rtl/dac_update_pkg.sv
/*
  Types shared by the converter update and latch control modules.
  Assumes the constants header is on the include path.
*/
package dac_update_pkg;
  `include "dac_update_cfg.svh"

  typedef logic [7:0]  byte_t;
  typedef logic [11:0] conv_word_t;
  typedef logic [1:0]  update_mode_t;
  typedef logic [2:0]  word_alignment_t;
endpackage

// file: rtl/word_align.sv
/*
  Assembles the 12-bit converter word from the high and low data bytes
  according to the alignment field. Purely combinational.
  Assumes the caller registers the result.
*/
`timescale 1ns/100ps

`include "dac_update_cfg.svh"

module word_align
  import dac_update_pkg::*;
(
  // Byte inputs
  input  wire byte_t           high_i,
  input  wire byte_t           low_i,
  // Alignment select
  input  wire word_alignment_t word_alignment_i,
  // Assembled word
  output conv_word_t           word_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Alignment selection
  wire         wide_sel = word_alignment_i[2];
  conv_word_t  word_nib;
  conv_word_t  word_five;
  conv_word_t  word_six;
  conv_word_t  word_seven;
  conv_word_t  word_eight;

  // Candidate words for each alignment
  assign word_nib   = {high_i[3:0], low_i[7:0]};  // R10
  assign word_five  = {high_i[4:0], low_i[7:1]};  // R05
  assign word_six   = {high_i[5:0], low_i[7:2]};  // R05
  assign word_seven = {high_i[6:0], low_i[7:3]};  // R05
  assign word_eight = {high_i[7:0], low_i[7:4]};  // R04

  // Field decode
  assign word_o = wide_sel                             ? word_eight :  // R10
                  (word_alignment_i == `FMT_FIVE)      ? word_five  :
                  (word_alignment_i == `FMT_SIX)       ? word_six   :
                  (word_alignment_i == `FMT_SEVEN)     ? word_seven :
                                                         word_nib;

endmodule // word_align

// file: verification/dac_update_latch_control_asserts.sv
/* Checker of latch transfer, enable and alignment timing.
   Assumes binding to the top module; sees its ports only. */
`timescale 1ns/100ps
module dac_update_latch_control_asserts
  import dac_update_pkg::*;
(
  // Clock, reset, bus and timer inputs
  input wire logic       clk_i, reset_i, sfr_wr_i,
  input wire byte_t      sfr_addr_i, sfr_wdata_i,
  input wire logic       timer2_ovf_i, timer3_ovf_i, timer4_ovf_i,
  // Converter outputs
  input wire conv_word_t conv_data_o,
  input wire logic       conv_enable_o, conv_out_en_o, conv_update_o
);
  logic [4:0] ctl_r;
  byte_t      lo_r;
  wire [1:0]  mode_w = ctl_r[4:3];
  wire        trig_w = (mode_w == 2'h0 && sfr_wr_i && sfr_addr_i == 8'hD3)
    || (mode_w == 2'h1 && timer3_ovf_i) || (mode_w == 2'h2 && timer4_ovf_i)
    || (mode_w == 2'h3 && timer2_ovf_i);
  // Shadow of control fields and low byte
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctl_r <= 5'h00;
      lo_r  <= 8'h00;
    end else if (sfr_wr_i && sfr_addr_i == 8'hD4) ctl_r <= sfr_wdata_i[4:0];
    else if (sfr_wr_i && sfr_addr_i == 8'hD2) lo_r <= sfr_wdata_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence hi_wr; sfr_wr_i && sfr_addr_i == 8'hD3; endsequence
  sequence ctl_wr; sfr_wr_i && sfr_addr_i == 8'hD4; endsequence
  chk_high_write_update: assert property (mode_w == 2'h0 ##0 hi_wr |=> conv_update_o)
    else $error("no transfer after high write");
  chk_t3_update: assert property (mode_w == 2'h1 && timer3_ovf_i |=> conv_update_o)
    else $error("no transfer on timer 3");
  chk_t4_t2_update: assert property ((mode_w == 2'h2 && timer4_ovf_i)
    || (mode_w == 2'h3 && timer2_ovf_i) |=> conv_update_o) else $error("no timer transfer");
  chk_no_other_update: assert property (!trig_w |=> !conv_update_o)
    else $error("transfer without cause");
  chk_data_hold: assert property (!conv_update_o |-> $stable(conv_data_o))
    else $error("latch changed without transfer");
  chk_enable_follow: assert property (ctl_wr |=> conv_enable_o == $past(sfr_wdata_i[7]))
    else $error("enable does not follow bit 7");
  chk_enable_hold: assert property (!(sfr_wr_i && sfr_addr_i == 8'hD4)
    |=> $stable(conv_enable_o))
    else $error("enable changed without write");
  chk_hiz_disabled: assert property (conv_out_en_o == conv_enable_o)
    else $error("output drive disagrees with enable");
  chk_eight_bit_align: assert property (mode_w == 2'h0 && ctl_r[2] ##0 hi_wr
    |=> conv_data_o == {$past(sfr_wdata_i), $past(lo_r[7:4])}) else $error("bad 8-bit form");
  chk_nibble_align: assert property (mode_w == 2'h0 && ctl_r[2:0] == 3'h0 ##0 hi_wr
    |=> conv_data_o == {$past(sfr_wdata_i[3:0]), $past(lo_r)}) else $error("bad nibble form");
  chk_five_bit_align: assert property (mode_w == 2'h0 && ctl_r[2:0] == 3'h1 ##0 hi_wr
    |=> conv_data_o == {$past(sfr_wdata_i[4:0]), $past(lo_r[7:1])}) else $error("bad 5-bit form");
endmodule // dac_update_latch_control_asserts
bind dac_update_latch_control dac_update_latch_control_asserts chk_u (.clk_i(clk_i),
  .reset_i(reset_i), .sfr_wr_i(sfr_wr_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
  .timer2_ovf_i(timer2_ovf_i), .timer3_ovf_i(timer3_ovf_i), .timer4_ovf_i(timer4_ovf_i),
  .conv_data_o(conv_data_o), .conv_enable_o(conv_enable_o), .conv_out_en_o(conv_out_en_o),
  .conv_update_o(conv_update_o));

// file: verification/timer_ovf_model.sv
/* Timer overflow sources: one pulse a set delay after a fire request.
   Assumes requests one cycle long, bit 0 timer 2, 1 timer 3, 2 timer 4. */
`timescale 1ns/100ps
module timer_ovf_model (
  // Request and pulses
  input  wire logic [2:0] fire_i,
  input  wire logic       clk_i,
  input  wire logic [3:0] delay_i,
  output logic      [2:0] ovf_o
);
  logic [3:0] cnt_r = 4'h0;
  logic [2:0] sel_r = 3'h0;
  initial ovf_o = 3'h0;
  // Count down, pulse once on expiry
  always @(posedge clk_i) begin
    ovf_o <= (cnt_r == 4'h1) ? sel_r : 3'h0;
    if (fire_i != 3'h0) begin
      sel_r <= fire_i;
      cnt_r <= delay_i + 4'h1;
    end else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
endmodule // timer_ovf_model

// file: verification/dac_update_latch_control_test.sv
/* Self-checking bench of the converter latch control block.
   Assumes the timer model drives the overflow inputs. */
`timescale 1ns/100ps
module dac_update_latch_control_test;
  import dac_update_pkg::*;
  logic       clk_i = 1'b0, reset_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
  byte_t      sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, last_h = 8'h00;
  logic [2:0] fire_r = 3'h0, ovf_w;
  logic [3:0] delay_r = 4'h0;
  conv_word_t conv_data_o, word_r = 12'h000;
  logic       conv_enable_o, conv_out_en_o, conv_update_o;
  int         bad_count = 0, n_tests = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  dac_update_latch_control dut_u (.clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .timer2_ovf_i(ovf_w[0]), .timer3_ovf_i(ovf_w[1]),
    .timer4_ovf_i(ovf_w[2]), .conv_data_o(conv_data_o), .conv_enable_o(conv_enable_o),
    .conv_out_en_o(conv_out_en_o), .conv_update_o(conv_update_o));
  timer_ovf_model model_u (.clk_i(clk_i), .fire_i(fire_r), .delay_i(delay_r), .ovf_o(ovf_w));
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test;
    end
  end
  task tick; @(posedge clk_i) #1; endtask
  task check(input logic [11:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task wr(input byte_t a, d);
    tick; sfr_addr_i = a; sfr_wdata_i = d; sfr_wr_i = 1'b1;
    tick; sfr_wr_i = 1'b0;
  endtask
  task rd(input byte_t a, exp);
    tick; sfr_addr_i = a; sfr_rd_i = 1'b1;
    tick; sfr_rd_i = 1'b0;
    check({4'h0, sfr_rdata_o}, {4'h0, exp});
  endtask
  function automatic conv_word_t align(input byte_t h, l, input int f);
    int n = (f > 3) ? 8 : f + 4;
    return 12'((32'({h, l}) & ((32'h1 << (8 + n)) - 1)) >> (n - 4));
  endfunction
  task reset_values;
    rd(8'hD2, 8'h00); rd(8'hD3, 8'h00); rd(8'hD4, 8'h00); rd(8'hD5, 8'h00);
    check(conv_data_o, 12'h000);
  endtask
  task on_write_formats;
    for (int f = 0; f < 8; f++) begin
      wr(8'hD4, 8'h80 | 8'(f)); wr(8'hD2, 8'hA5 ^ 8'(f)); tick;
      check(conv_data_o, word_r);
      last_h = 8'h3C + 8'(f * 37);
      wr(8'hD3, last_h);
      check(12'(conv_update_o), 12'h001);
      tick;
      word_r = align(last_h, 8'hA5 ^ 8'(f), f);
      check(conv_data_o, word_r);
      check(12'({conv_enable_o, conv_out_en_o}), 12'h003);
      rd(8'hD2, 8'hA5 ^ 8'(f));
    end
  endtask
  task timer_modes;
    logic [2:0] sel;
    for (int m = 1; m < 4; m++) begin
      sel = (m == 3) ? 3'h1 : 3'(1 << m);
      wr(8'hD4, 8'h84 | 8'(m << 3)); wr(8'hD2, 8'h17 * 8'(m)); wr(8'hD3, 8'hE1 - 8'(m));
      tick; check(conv_data_o, word_r);
      rd(8'hD3, last_h);
      delay_r = 4'h0;
      fire_r = ~sel; tick; fire_r = 3'h0; repeat (3) tick;
      check(conv_data_o, word_r);
      delay_r = 4'(m * 3); fire_r = sel; tick; fire_r = 3'h0;
      for (int k = 0; k < 20 && conv_update_o !== 1'b1; k++) tick;
      check(12'(conv_update_o), 12'h001);
      word_r = align(8'hE1 - 8'(m), 8'h17 * 8'(m), 4); last_h = 8'hE1 - 8'(m);
      check(conv_data_o, word_r);
    end
  endtask
  task enable_off;
    wr(8'hD4, 8'h60); tick;
    check(12'({conv_enable_o, conv_out_en_o}), 12'h000);
    rd(8'hD4, 8'h00);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    reset_values; on_write_formats; timer_modes; enable_off;
    finish_test;
  end
endmodule // dac_update_latch_control_test
